// ### jump_and_load_execute.v
`timescale 1ns/1ps
`include "jump_and_load_defs.vh"
module jump_and_load_execute #(
  parameter PROG_WRITABLE = 1
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire start,
  input wire pc_load,
  input wire [15:0] pc_load_value,
  input wire [7:0] reg_pointer,
  input wire [7:0] flags,
  // Status
  output wire busy,
  output wire done,
  output wire illegal,
  output wire [15:0] program_counter,
  // Program memory port, read data valid in the same cycle as the address
  output reg [15:0] pm_addr,
  output reg pm_re,
  output reg pm_we,
  output reg [7:0] pm_wdata,
  input wire [7:0] pm_rdata,
  // Register file port, read data valid in the same cycle as the address
  output reg [7:0] rf_addr,
  output reg rf_re,
  output reg rf_we,
  output reg [7:0] rf_wdata,
  input wire [7:0] rf_rdata
);

  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_FETCH = 7'h02;
  localparam [6:0] S_OP1 = 7'h04;
  localparam [6:0] S_OP2 = 7'h08;
  localparam [6:0] S_OP3 = 7'h10;
  localparam [6:0] S_EXEC = 7'h20;
  localparam [6:0] S_DONE = 7'h40;

  reg [6:0] state_reg, state_next;
  reg [2:0] step_reg, step_next;
  reg [15:0] pc_reg, pc_next;
  reg [7:0] op_reg, op_next;
  reg [7:0] b1_reg, b1_next;
  reg [7:0] b2_reg, b2_next;
  reg [7:0] t1_reg, t1_next;
  reg [7:0] t2_reg, t2_next;
  reg [7:0] t3_reg, t3_next;
  reg illegal_reg, illegal_next;
  reg [15:0] pm_addr_next;
  reg pm_re_next, pm_we_next;
  reg [7:0] pm_wdata_next;
  reg [7:0] rf_addr_next;
  reg rf_re_next, rf_we_next;
  reg [7:0] rf_wdata_next;
  reg [15:0] inc_pair;

  function cond_true;
    input [3:0] code;
    input [7:0] f;
    reg c, z, s, v;
    begin
      c = f[`FLAG_C];
      z = f[`FLAG_Z];
      s = f[`FLAG_S];
      v = f[`FLAG_V];
      case (code)
        `COND_NEVER: cond_true = 1'b0;
        `COND_LT: cond_true = s ^ v;
        `COND_LE: cond_true = z | (s ^ v);
        `COND_ULE: cond_true = c | z;
        `COND_OV: cond_true = v;
        `COND_MI: cond_true = s;
        `COND_EQ: cond_true = z;
        `COND_ULT: cond_true = c;
        `COND_ALWAYS: cond_true = 1'b1;
        `COND_GE: cond_true = ~(s ^ v);
        `COND_GT: cond_true = ~(z | (s ^ v));
        `COND_UGT: cond_true = ~(c | z);
        `COND_NOV: cond_true = ~v;
        `COND_PL: cond_true = ~s;
        `COND_NE: cond_true = ~z;
        default: cond_true = ~c;
      endcase
    end
  endfunction

  // Working register n sits in the page chosen by the pointer
  function [7:0] wreg;
    input [3:0] n;
    begin
      wreg = {reg_pointer[7:4], n};
    end
  endfunction

  // 8-bit operand field, Ex meaning working register x
  function [7:0] reg_addr;
    input [7:0] b;
    begin
      if (b[7:4] == `WREG_PREFIX)
        reg_addr = wreg(b[3:0]);
      else
        reg_addr = b;
    end
  endfunction

  // Wraps within the 256-byte register space on purpose
  function [7:0] add8;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] sum;
    begin
      sum = {1'b0, a} + {1'b0, b};
      add8 = sum[7:0];
    end
  endfunction

  function [15:0] add16;
    input [15:0] a;
    input [15:0] b;
    reg [16:0] sum;
    begin
      sum = {1'b0, a} + {1'b0, b};
      add16 = sum[15:0];
    end
  endfunction

  function is_three_byte;
    input [7:0] op;
    begin
      is_three_byte = (op[3:0] == `NIB_ABS_JUMP) ||
        (op == `OP_MV_R_R) || (op == `OP_MV_R_IRS) ||
        (op == `OP_MV_R_IM) || (op == `OP_MV_IR_IM) ||
        (op == `OP_MV_IRD_R) || (op == `OP_MV_X_LOAD) ||
        (op == `OP_MV_X_STORE);
    end
  endfunction

  function is_legal;
    input [7:0] op;
    begin
      case (op)
        `OP_JUMP_IND, `OP_MV_R_IR, `OP_MV_IR_R, `OP_MV_R_R,
        `OP_MV_R_IRS, `OP_MV_R_IM, `OP_MV_IR_IM, `OP_MV_IRD_R,
        `OP_MV_X_LOAD, `OP_MV_X_STORE, `OP_CONST_READ,
        `OP_BLOCK_READ, `OP_BLOCK_WRITE: is_legal = 1'b1;
        `OP_CONST_WRITE: is_legal = (PROG_WRITABLE != 0);
        default: is_legal = (op[3:0] == `NIB_ABS_JUMP) ||
          (op[3:0] == `NIB_REL_JUMP) || (op[3:0] == `NIB_MV_IMM) ||
          (op[3:0] == `NIB_MV_R_FROM_REG) ||
          (op[3:0] == `NIB_MV_REG_FROM_R);
      endcase
    end
  endfunction

  always @* begin
    state_next = state_reg;
    step_next = step_reg;
    pc_next = pc_reg;
    op_next = op_reg;
    b1_next = b1_reg;
    b2_next = b2_reg;
    t1_next = t1_reg;
    t2_next = t2_reg;
    t3_next = t3_reg;
    illegal_next = 1'b0;
    pm_addr_next = pm_addr;
    pm_re_next = 1'b0;
    pm_we_next = 1'b0;
    pm_wdata_next = pm_wdata;
    rf_addr_next = rf_addr;
    rf_re_next = 1'b0;
    rf_we_next = 1'b0;
    rf_wdata_next = rf_wdata;
    inc_pair = add16({t1_reg, t2_reg}, 16'h0001);
    case (state_reg)
      S_IDLE: begin
        if (pc_load)
          pc_next = pc_load_value;
        else if (start)
          state_next = S_FETCH;
      end
      S_FETCH: begin
        pm_addr_next = pc_reg;
        pm_re_next = 1'b1;
        pc_next = add16(pc_reg, 16'h0001);
        state_next = S_OP1;
      end
      S_OP1: begin
        op_next = pm_rdata;
        pm_addr_next = pc_reg;
        pm_re_next = 1'b1;
        pc_next = add16(pc_reg, 16'h0001);
        state_next = S_OP2;
      end
      S_OP2: begin
        b1_next = pm_rdata;
        step_next = 3'h0;
        if (!is_legal(op_reg)) begin
          illegal_next = 1'b1;
          state_next = S_IDLE;
        end else if (is_three_byte(op_reg)) begin
          pm_addr_next = pc_reg;
          pm_re_next = 1'b1;
          pc_next = add16(pc_reg, 16'h0001);
          state_next = S_OP3;
        end else begin
          state_next = S_EXEC;
        end
      end
      S_OP3: begin
        b2_next = pm_rdata;
        state_next = S_EXEC;
      end
      S_EXEC: begin
        // no flag write path exists in this block
        step_next = step_reg + 3'h1;
        if (op_reg[3:0] == `NIB_ABS_JUMP) begin
          if (cond_true(op_reg[7:4], flags))
            pc_next = {b1_reg, b2_reg};
          state_next = S_DONE;
        end else if (op_reg == `OP_JUMP_IND) begin
          // no condition, high byte at the named address, low byte at the next
          if (step_reg == 3'h0) begin
            rf_addr_next = reg_addr(b1_reg);
            rf_re_next = 1'b1;
          end else if (step_reg == 3'h1) begin
            t1_next = rf_rdata;
            rf_addr_next = add8(reg_addr(b1_reg), 8'h01);
            rf_re_next = 1'b1;
          end else begin
            pc_next = {t1_reg, rf_rdata};
            state_next = S_DONE;
          end
        end else if (op_reg[3:0] == `NIB_REL_JUMP) begin
          // pc_reg already points past the displacement
          if (cond_true(op_reg[7:4], flags))
            pc_next = add16(pc_reg, {{8{b1_reg[7]}}, b1_reg});
          state_next = S_DONE;
        end else if (op_reg[3:0] == `NIB_MV_IMM) begin
          rf_addr_next = wreg(op_reg[7:4]);
          rf_wdata_next = b1_reg;
          rf_we_next = 1'b1;
          state_next = S_DONE;
        end else if (op_reg[3:0] == `NIB_MV_R_FROM_REG ||
                     op_reg[3:0] == `NIB_MV_REG_FROM_R) begin
          if (step_reg == 3'h0) begin
            rf_addr_next = (op_reg[0]) ? wreg(op_reg[7:4]) : reg_addr(b1_reg);
            rf_re_next = 1'b1;
          end else begin
            // Full address, no working register shortcut
            rf_addr_next = (op_reg[0]) ? b1_reg : wreg(op_reg[7:4]);
            rf_wdata_next = rf_rdata;
            rf_we_next = 1'b1;
            state_next = S_DONE;
          end
        end else if (op_reg == `OP_MV_R_IM) begin
          rf_addr_next = reg_addr(b1_reg);
          rf_wdata_next = b2_reg;
          rf_we_next = 1'b1;
          state_next = S_DONE;
        end else if (op_reg == `OP_MV_R_R || op_reg == `OP_MV_R_IRS ||
                     op_reg == `OP_MV_R_IR || op_reg == `OP_MV_X_LOAD ||
                     op_reg == `OP_MV_IR_IM) begin
          // Fetch source (or its pointer, destination pointer for OP_MV_IR_IM), then resolve (not for OP_MV_R_R or OP_MV_IR_IM), then write
          if (step_reg == 3'h0) begin
            if (op_reg == `OP_MV_R_IR || op_reg == `OP_MV_X_LOAD)
              rf_addr_next = wreg(b1_reg[3:0]);
            else
              rf_addr_next = reg_addr(b1_reg);
            rf_re_next = 1'b1;
          end else if (step_reg == 3'h1 &&
                       op_reg != `OP_MV_R_R && op_reg != `OP_MV_IR_IM) begin
            if (op_reg == `OP_MV_X_LOAD)
              rf_addr_next = add8(b2_reg, rf_rdata);
            else
              rf_addr_next = rf_rdata;
            rf_re_next = 1'b1;
          end else begin
            if (op_reg == `OP_MV_R_R || op_reg == `OP_MV_R_IRS)
              rf_addr_next = reg_addr(b2_reg);
            else if (op_reg == `OP_MV_IR_IM)
              rf_addr_next = rf_rdata;
            else
              rf_addr_next = wreg(b1_reg[7:4]);
            rf_wdata_next = (op_reg == `OP_MV_IR_IM) ? b2_reg : rf_rdata;
            rf_we_next = 1'b1;
            state_next = S_DONE;
          end
        end else if (op_reg == `OP_MV_IR_R || op_reg == `OP_MV_IRD_R ||
                     op_reg == `OP_MV_X_STORE) begin
          // Destination address first, then source value
          if (step_reg == 3'h0) begin
            if (op_reg == `OP_MV_IR_R)
              rf_addr_next = wreg(b1_reg[7:4]);
            else if (op_reg == `OP_MV_IRD_R)
              rf_addr_next = reg_addr(b2_reg);
            else
              rf_addr_next = wreg(b1_reg[3:0]);
            rf_re_next = 1'b1;
          end else if (step_reg == 3'h1) begin
            if (op_reg == `OP_MV_X_STORE)
              t1_next = add8(b2_reg, rf_rdata);
            else
              t1_next = rf_rdata;
            if (op_reg == `OP_MV_IR_R)
              rf_addr_next = wreg(b1_reg[3:0]);
            else if (op_reg == `OP_MV_IRD_R)
              rf_addr_next = reg_addr(b1_reg);
            else
              rf_addr_next = wreg(b1_reg[7:4]);
            rf_re_next = 1'b1;
          end else begin
            rf_addr_next = t1_reg;
            rf_wdata_next = rf_rdata;
            rf_we_next = 1'b1;
            state_next = S_DONE;
          end
        end else begin
          // Constant moves: b1 high nibble register, low nibble pair
          case (step_reg)
            3'h0: begin
              rf_addr_next = wreg({b1_reg[3:1], 1'b0});
              rf_re_next = 1'b1;
            end
            3'h1: begin
              t1_next = rf_rdata;
              rf_addr_next = wreg({b1_reg[3:1], 1'b1});
              rf_re_next = 1'b1;
            end
            3'h2: begin
              t2_next = rf_rdata;
              if (op_reg == `OP_CONST_READ) begin
                pm_addr_next = {t1_reg, rf_rdata};
                pm_re_next = 1'b1;
              end else begin
                rf_addr_next = wreg(b1_reg[7:4]);
                rf_re_next = 1'b1;
              end
            end
            3'h3: begin
              if (op_reg == `OP_CONST_READ) begin
                rf_addr_next = wreg(b1_reg[7:4]);
                rf_wdata_next = pm_rdata;
                rf_we_next = 1'b1;
                state_next = S_DONE;
              end else if (op_reg == `OP_CONST_WRITE) begin
                pm_addr_next = {t1_reg, t2_reg};
                pm_wdata_next = rf_rdata;
                pm_we_next = 1'b1;
                state_next = S_DONE;
              end else begin
                t3_next = rf_rdata;
                if (op_reg == `OP_BLOCK_READ) begin
                  pm_addr_next = {t1_reg, t2_reg};
                  pm_re_next = 1'b1;
                end else begin
                  rf_addr_next = rf_rdata;
                  rf_re_next = 1'b1;
                end
              end
            end
            3'h4: begin
              if (op_reg == `OP_BLOCK_READ) begin
                rf_addr_next = t3_reg;
                rf_wdata_next = pm_rdata;
                rf_we_next = 1'b1;
              end else if (PROG_WRITABLE != 0) begin
                pm_addr_next = {t1_reg, t2_reg};
                pm_wdata_next = rf_rdata;
                pm_we_next = 1'b1;
              end
            end
            3'h5: begin
              rf_addr_next = wreg(b1_reg[7:4]);
              rf_wdata_next = add8(t3_reg, 8'h01);
              rf_we_next = 1'b1;
            end
            3'h6: begin
              rf_addr_next = wreg({b1_reg[3:1], 1'b1});
              rf_wdata_next = inc_pair[7:0];
              rf_we_next = 1'b1;
            end
            default: begin
              rf_addr_next = wreg({b1_reg[3:1], 1'b0});
              rf_wdata_next = inc_pair[15:8];
              rf_we_next = 1'b1;
              state_next = S_DONE;
            end
          endcase
        end
      end
      S_DONE: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      step_reg <= 3'h0;
      pc_reg <= `PC_RESET;
      op_reg <= 8'h00;
      b1_reg <= 8'h00;
      b2_reg <= 8'h00;
      t1_reg <= 8'h00;
      t2_reg <= 8'h00;
      t3_reg <= 8'h00;
      illegal_reg <= 1'b0;
      pm_addr <= 16'h0000;
      pm_re <= 1'b0;
      pm_we <= 1'b0;
      pm_wdata <= 8'h00;
      rf_addr <= 8'h00;
      rf_re <= 1'b0;
      rf_we <= 1'b0;
      rf_wdata <= 8'h00;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      pc_reg <= pc_next;
      op_reg <= op_next;
      b1_reg <= b1_next;
      b2_reg <= b2_next;
      t1_reg <= t1_next;
      t2_reg <= t2_next;
      t3_reg <= t3_next;
      illegal_reg <= illegal_next;
      pm_addr <= pm_addr_next;
      pm_re <= pm_re_next;
      pm_we <= pm_we_next;
      pm_wdata <= pm_wdata_next;
      rf_addr <= rf_addr_next;
      rf_re <= rf_re_next;
      rf_we <= rf_we_next;
      rf_wdata <= rf_wdata_next;
    end
  end

  assign busy = (state_reg != S_IDLE);
  assign done = (state_reg == S_DONE);
  assign illegal = illegal_reg;
  assign program_counter = pc_reg;

endmodule // jump_and_load_execute

// ### jump_and_load_defs.vh
`ifndef JUMP_AND_LOAD_DEFS_VH
`define JUMP_AND_LOAD_DEFS_VH

// Flag bit positions inside the flags byte
`define FLAG_C 7
`define FLAG_Z 6
`define FLAG_S 5
`define FLAG_V 4

// Reset values
`define PC_RESET 16'h0000

// Low-nibble opcode groups, high nibble is condition or register
`define NIB_ABS_JUMP 4'hD
`define NIB_REL_JUMP 4'hB
`define NIB_MV_IMM 4'hC
`define NIB_MV_R_FROM_REG 4'h8
`define NIB_MV_REG_FROM_R 4'h9

// Full opcodes
`define OP_JUMP_IND 8'h30
`define OP_MV_R_IR 8'hE3
`define OP_MV_IR_R 8'hF3
`define OP_MV_R_R 8'hE4
`define OP_MV_R_IRS 8'hE5
`define OP_MV_R_IM 8'hE6
`define OP_MV_IR_IM 8'hE7
`define OP_MV_IRD_R 8'hF5
`define OP_MV_X_LOAD 8'hC7
`define OP_MV_X_STORE 8'hD7
`define OP_CONST_READ 8'hC2
`define OP_CONST_WRITE 8'hD2
`define OP_BLOCK_READ 8'hC3
`define OP_BLOCK_WRITE 8'hD3

// Operand prefix selecting a working register in an 8-bit field
`define WREG_PREFIX 4'hE

// Condition codes
`define COND_NEVER 4'h0
`define COND_LT 4'h1
`define COND_LE 4'h2
`define COND_ULE 4'h3
`define COND_OV 4'h4
`define COND_MI 4'h5
`define COND_EQ 4'h6
`define COND_ULT 4'h7
`define COND_ALWAYS 4'h8
`define COND_GE 4'h9
`define COND_GT 4'hA
`define COND_UGT 4'hB
`define COND_NOV 4'hC
`define COND_PL 4'hD
`define COND_NE 4'hE
`define COND_UGE 4'hF

`endif

// ### jump_and_load_monitor.sv
`timescale 1ns/1ps
module jump_and_load_monitor #(
  parameter PROG_WRITABLE = 1
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Control
  input logic start,
  input logic pc_load,
  input logic [15:0] pc_load_value,
  input logic [7:0] reg_pointer,
  input logic [7:0] flags,
  // Status
  input logic busy,
  input logic done,
  input logic illegal,
  input logic [15:0] program_counter,
  // Program memory port
  input logic [15:0] pm_addr,
  input logic pm_re,
  input logic pm_we,
  input logic [7:0] pm_wdata,
  input logic [7:0] pm_rdata,
  // Register file port
  input logic [7:0] rf_addr,
  input logic rf_re,
  input logic rf_we,
  input logic [7:0] rf_wdata,
  input logic [7:0] rf_rdata
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_fetch_at_pc: assert property (
    (!busy && start && !pc_load) |-> ##2 (pm_re &&
      pm_addr == $past(program_counter)))
    else $error("fetch did not read at the program counter");
  a_done_then_idle: assert property (
    done |=> !busy && !done)
    else $error("block not idle after done");
  a_done_in_busy: assert property (
    done |-> busy)
    else $error("done outside an instruction");
  a_busy_bounded: assert property (
    $rose(busy) |-> ##[1:11] (done || illegal))
    else $error("instruction did not finish in time");
  a_illegal_no_write: assert property (
    illegal |-> !pm_we && !rf_we)
    else $error("write during refused opcode");
  a_no_prog_write: assert property (
    (PROG_WRITABLE == 0) |-> !pm_we)
    else $error("program write on read-only program memory");
  a_pm_write_single: assert property (
    pm_we |=> (!pm_we) [*5])
    else $error("more than one program byte written");
  a_idle_quiet: assert property (
    !busy |-> !pm_we && !rf_we && !pm_re && !rf_re)
    else $error("memory strobe while idle");
  a_pc_idle_hold: assert property (
    (!busy && !pc_load && !start) |=> program_counter == $past(program_counter))
    else $error("program counter moved while idle");
endmodule // jump_and_load_monitor

bind jump_and_load_execute jump_and_load_monitor #(
  .PROG_WRITABLE(PROG_WRITABLE)
) jump_and_load_monitor_inst (
  .clk(clk), .rstn(rstn), .start(start), .pc_load(pc_load),
  .pc_load_value(pc_load_value), .reg_pointer(reg_pointer), .flags(flags),
  .busy(busy), .done(done), .illegal(illegal),
  .program_counter(program_counter), .pm_addr(pm_addr), .pm_re(pm_re),
  .pm_we(pm_we), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata),
  .rf_addr(rf_addr), .rf_re(rf_re), .rf_we(rf_we), .rf_wdata(rf_wdata),
  .rf_rdata(rf_rdata)
);

// ### prog_reg_memory.sv
`timescale 1ns/1ps
module prog_reg_memory (
  // Clock
  input logic clk,
  // Program memory side
  input logic [15:0] pm_addr,
  input logic pm_re,
  input logic pm_we,
  input logic [7:0] pm_wdata,
  output logic [7:0] pm_rdata,
  // Register file side
  input logic [7:0] rf_addr,
  input logic rf_re,
  input logic rf_we,
  input logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata
);
  logic [7:0] pm [0:65535];
  logic [7:0] rf [0:255];
  logic [7:0] pm_last = 8'h00;
  logic [7:0] rf_last = 8'h00;
  // Released port shows inverted data so a late sample cannot pass
  assign pm_rdata = pm_re ? pm[pm_addr] : ~pm_last;
  assign rf_rdata = rf_re ? rf[rf_addr] : ~rf_last;
  always @(posedge clk) begin
    if (pm_we) pm[pm_addr] <= pm_wdata;
    if (rf_we) rf[rf_addr] <= rf_wdata;
    if (pm_re) pm_last <= pm[pm_addr];
    if (rf_re) rf_last <= rf[rf_addr];
  end
  // Known contents: a register holds its own address
  task automatic fill();
    for (int a = 0; a < 65536; a++) pm[a] = a[15:8] ^ a[7:0];
    for (int a = 0; a < 256; a++) rf[a] = a[7:0];
  endtask
endmodule // prog_reg_memory

// ### jump_and_load_execute_bench.sv
`timescale 1ns/1ps
module jump_and_load_execute_bench;
  typedef struct packed {
    logic [23:0] code;
    logic [7:0] flg;
    logic [15:0] pc;
    logic [1:0] wk;
    logic [15:0] wa;
    logic [7:0] wv;
  } row_t;
  logic clk, rstn, start, pc_load, busy, done, illegal;
  logic [15:0] pc_load_value, program_counter, pm_addr;
  logic [7:0] reg_pointer, flags, pm_wdata, pm_rdata;
  logic pm_re, pm_we, rf_re, rf_we;
  logic [7:0] rf_addr, rf_wdata, rf_rdata;
  int err_count = 0;
  int checked = 0;
  row_t rows [0:21];

  jump_and_load_execute jump_and_load_execute_inst (
    .clk(clk), .rstn(rstn), .start(start), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .reg_pointer(reg_pointer), .flags(flags),
    .busy(busy), .done(done), .illegal(illegal),
    .program_counter(program_counter), .pm_addr(pm_addr), .pm_re(pm_re),
    .pm_we(pm_we), .pm_wdata(pm_wdata), .pm_rdata(pm_rdata),
    .rf_addr(rf_addr), .rf_re(rf_re), .rf_we(rf_we), .rf_wdata(rf_wdata),
    .rf_rdata(rf_rdata));
  prog_reg_memory mem (
    .clk(clk), .pm_addr(pm_addr), .pm_re(pm_re), .pm_we(pm_we),
    .pm_wdata(pm_wdata), .pm_rdata(pm_rdata), .rf_addr(rf_addr),
    .rf_re(rf_re), .rf_we(rf_we), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
      input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic do_reset();
    rstn = 1'h0;
    tick();
    tick();
    chk("busy in reset", 16'h0000, {15'h0000, busy});
    chk("pc in reset", 16'h0000, program_counter);
    chk("strobes in reset", 16'h0000, {12'h000, pm_re, pm_we, rf_re, rf_we});
    rstn = 1'h1;
    $display("reset test done");
  endtask

  task automatic wait_end();
    int n;
    n = 0;
    while (done !== 1'h1 && illegal !== 1'h1) begin
      tick();
      n++;
      if (n > 40) begin
        err_count++;
        $display("ERROR completion expected done seen none");
        end_of_test();
      end
    end
  endtask

  task automatic launch(input logic [15:0] pc, input logic hold);
    tick();
    pc_load = 1'h1;
    pc_load_value = pc;
    tick();
    pc_load = 1'h0;
    start = 1'h1;
    tick();
    start = hold;
  endtask

  task automatic run_row(input row_t r);
    logic got_ill;
    mem.fill();
    {mem.pm[16'h1000], mem.pm[16'h1001], mem.pm[16'h1002]} = r.code;
    flags = r.flg;
    launch(16'h1000, 1'h0);
    wait_end();
    got_ill = illegal;
    tick();
    chk("program_counter", r.pc, program_counter);
    if (r.wk == 2'h1)
      chk("register byte", {8'h00, r.wv}, {8'h00, mem.rf[r.wa[7:0]]});
    if (r.wk == 2'h2)
      chk("program byte", {8'h00, r.wv}, {8'h00, mem.pm[r.wa]});
    if (r.wk == 2'h3)
      chk("illegal", 16'h0001, {15'h0000, got_ill});
  endtask

  initial begin
    rstn = 1'h0;
    start = 1'h0;
    pc_load = 1'h0;
    pc_load_value = 16'h0000;
    reg_pointer = 8'h30;
    flags = 8'h00;
    rows = '{
      {24'h7D1520, 8'h80, 16'h1520, 2'h0, 16'h0000, 8'h00},
      {24'h7D1520, 8'h70, 16'h1003, 2'h0, 16'h0000, 8'h00},
      {24'h30E200, 8'h00, 16'h3233, 2'h0, 16'h0000, 8'h00},
      {24'h8BD300, 8'h00, 16'h0FD5, 2'h0, 16'h0000, 8'h00},
      {24'h8B7F00, 8'h00, 16'h1081, 2'h0, 16'h0000, 8'h00},
      {24'h8B8000, 8'h00, 16'h0F82, 2'h0, 16'h0000, 8'h00},
      {24'hFC3400, 8'h00, 16'h1002, 2'h1, 16'h003F, 8'h34},
      {24'hF84500, 8'h00, 16'h1002, 2'h1, 16'h003F, 8'h45},
      {24'hE9E500, 8'h00, 16'h1002, 2'h1, 16'h00E5, 8'h3E},
      {24'hE3DC00, 8'h00, 16'h1002, 2'h1, 16'h003D, 8'h3C},
      {24'hF3DC00, 8'h00, 16'h1002, 2'h1, 16'h003D, 8'h3C},
      {24'hE44534, 8'h00, 16'h1003, 2'h1, 16'h0034, 8'h45},
      {24'hE54534, 8'h00, 16'h1003, 2'h1, 16'h0034, 8'h45},
      {24'hE634A4, 8'h00, 16'h1003, 2'h1, 16'h0034, 8'hA4},
      {24'hE7EEFC, 8'h00, 16'h1003, 2'h1, 16'h003E, 8'hFC},
      {24'hF54534, 8'h00, 16'h1003, 2'h1, 16'h0034, 8'h45},
      {24'hC7A024, 8'h00, 16'h1003, 2'h1, 16'h003A, 8'h54},
      {24'hD7A0F0, 8'h00, 16'h1003, 2'h1, 16'h0020, 8'h3A},
      {24'hC22600, 8'h00, 16'h1002, 2'h1, 16'h0032, 8'h01},
      {24'hD22600, 8'h00, 16'h1002, 2'h2, 16'h3637, 8'h32},
      {24'hD32600, 8'h00, 16'h1002, 2'h2, 16'h3637, 8'h32},
      {24'h000000, 8'h00, 16'h1002, 2'h3, 16'h0000, 8'h00}};
    do_reset();
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // Flags all clear, then all set, against every condition code
    for (int f = 0; f < 2; f++)
      for (int c = 0; c < 16; c++) begin
        logic hit;
        hit = f ? (c >= 2 && c <= 9) : c[3];
        run_row({c[3:0], 4'hB, 16'h1000, (f ? 8'hF0 : 8'h00),
          (hit ? 16'h1012 : 16'h1002), 2'h0, 24'h000000});
      end
    $display("condition code test done");
    // Two block moves back to back across a pair carry
    mem.fill();
    mem.rf[8'h32] = 8'h50;
    mem.rf[8'h36] = 8'h30;
    mem.rf[8'h37] = 8'hFF;
    {mem.pm[16'h1000], mem.pm[16'h1001]} = 16'hC326;
    {mem.pm[16'h1002], mem.pm[16'h1003]} = 16'hC326;
    launch(16'h1000, 1'h1);
    pc_load = 1'h1;
    pc_load_value = 16'h0000;
    tick();
    pc_load = 1'h0;
    wait_end();
    tick();
    wait_end();
    start = 1'h0;
    tick();
    chk("pc after two moves", 16'h1004, program_counter);
    chk("first byte", 16'h00CF, {8'h00, mem.rf[8'h50]});
    chk("second byte", 16'h0031, {8'h00, mem.rf[8'h51]});
    chk("address reg", 16'h0052, {8'h00, mem.rf[8'h32]});
    chk("address pair", 16'h3101, {mem.rf[8'h36], mem.rf[8'h37]});
    chk("source kept", 16'h00CF, {8'h00, mem.pm[16'h30FF]});
    $display("block move test done");
    launch(16'h1000, 1'h0);
    tick();
    tick();
    do_reset();
    end_of_test();
  end
endmodule // jump_and_load_execute_bench
